// file: dual_event_counter_params.svh
// constants for the dual event counter unit
// assumes inclusion by the package and by the design module
`ifndef DUAL_EVENT_COUNTER_PARAMS_SVH
`define DUAL_EVENT_COUNTER_PARAMS_SVH

`define CTR_WIDTH 40
`define CTRL_WIDTH 32
`define REG_SEL_WIDTH 2
`define SEL_CONTROL 2'h0
`define SEL_COUNTER_ZERO 2'h1
`define SEL_COUNTER_ONE 2'h2
`define EVENT_CODE_WIDTH 6
`define CODE_LO_ZERO 0
`define CODE_LO_ONE 16
`define CC_LO_ZERO 6
`define CC_LO_ONE 22
`define PIN_MODE_ZERO 9
`define PIN_MODE_ONE 25
`define CONTROL_RESET 32'h00000000
`define COUNTER_RESET 40'h0000000000
`define PIN_LAG_CYCLES 5
`define NUM_EVENTS 64

`endif

// file: dual_event_counter_pkg.sv
// types for the dual event counter unit
// assumes the params header sits in the same folder
`include "dual_event_counter_params.svh"

package dual_event_counter_pkg;

  // one counter's slice of the control register
  typedef struct packed {
    logic pin_mode;
    logic [2:0] count_control;
    logic [`EVENT_CODE_WIDTH-1:0] event_code;
  } counter_cfg_s;

  // register access request from the instruction path
  typedef struct packed {
    logic rd;
    logic wr;
    logic [`REG_SEL_WIDTH-1:0] sel;
    logic [`CTR_WIDTH-1:0] wdata;
  } reg_req_s;

endpackage

// file: dual_event_counter_unit.sv
// two 40-bit event/duration counters with indication pins
// assumes register access arrives from the model-register instruction
// decode with the current privilege level; events are core-clock synchronous
`timescale 1ns/100ps
`default_nettype none
`include "dual_event_counter_params.svh"

module dual_event_counter_unit
  import dual_event_counter_pkg::*;
#(
  parameter int CW = `CTR_WIDTH,
  parameter int LAG = `PIN_LAG_CYCLES,
  parameter int NEV = `NUM_EVENTS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register access from model_reg_read_instr / model_reg_write_instr
  input wire reg_req_s reg_req,
  input wire logic [1:0] current_privilege_level,
  output logic [CW-1:0] reg_rdata,
  output logic reg_fault,
  // event sources: per event code, occurrences this clock (0..2) and level
  input wire logic [NEV-1:0][1:0] event_occur,
  input wire logic [NEV-1:0] event_level,
  // debug breakpoint pin sharing
  input wire logic breakpoint_mode,
  input wire logic [1:0] breakpoint_match,
  // indication pins
  output logic indication_pin_zero,
  output logic indication_pin_one
);

  logic [`CTRL_WIDTH-1:0] counter_control_register;
  logic [`CTRL_WIDTH-1:0] next_control;
  logic [1:0][CW-1:0] counter_value;
  logic [1:0][CW-1:0] next_value;
  logic [1:0] inc_flag;
  logic [1:0] ovf_flag;
  logic [1:0][LAG-1:0] pin_pipe;
  logic [1:0][LAG-1:0] next_pipe;
  logic [CW-1:0] next_rdata;
  logic next_fault;
  logic [1:0] next_pin;
  logic [1:0] pin_out;
  counter_cfg_s [1:0] cfg;
  logic access_ok;
  logic [1:0] sel_ctr;

  // field slices of the control register
  assign cfg[0] = {counter_control_register[`PIN_MODE_ZERO],
                   counter_control_register[`CC_LO_ZERO +: 3],
                   counter_control_register[`CODE_LO_ZERO +:
                                            `EVENT_CODE_WIDTH]};
  assign cfg[1] = {counter_control_register[`PIN_MODE_ONE],
                   counter_control_register[`CC_LO_ONE +: 3],
                   counter_control_register[`CODE_LO_ONE +:
                                            `EVENT_CODE_WIDTH]};

  // only privilege level zero may reach the registers
  assign access_ok = (current_privilege_level == 2'h0);
  assign sel_ctr[0] = (reg_req.sel == `SEL_COUNTER_ZERO);
  assign sel_ctr[1] = (reg_req.sel == `SEL_COUNTER_ONE);

  // control register next value; whole word written at once
  always_comb begin
    next_control = counter_control_register;
    if (reg_req.wr && access_ok && reg_req.sel == `SEL_CONTROL) begin
      next_control = reg_req.wdata[`CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      counter_control_register <= `CONTROL_RESET;
    end else begin
      counter_control_register <= next_control;
    end
  end

  // counting: one identical slice per counter
  always_comb begin
    logic [1:0] amount;
    logic priv_ok;
    logic [CW:0] sum;
    amount = 2'h0;
    priv_ok = 1'b0;
    sum = '0;
    for (int i = 0; i < 2; i++) begin
      // low bit: levels 0-2, middle bit: level 3
      priv_ok = (current_privilege_level == 2'h3) ?
                cfg[i].count_control[1] : cfg[i].count_control[0];
      if (!priv_ok) begin
        amount = 2'h0;
      end else if (cfg[i].count_control[2]) begin
        amount = {1'b0, event_level[cfg[i].event_code]};
      end else begin
        amount = event_occur[cfg[i].event_code];
      end
      sum = {1'b0, counter_value[i]} + {{(CW-1){1'b0}}, amount};
      next_value[i] = sum[CW-1:0];
      inc_flag[i] = (amount != 2'h0);
      ovf_flag[i] = sum[CW];
      if (reg_req.wr && access_ok && sel_ctr[i]) begin
        next_value[i] = reg_req.wdata;
        // the load replaces the count, so no pin pulse this cycle
        inc_flag[i] = 1'b0;
        ovf_flag[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      counter_value <= {2{`COUNTER_RESET}};
    end else begin
      counter_value <= next_value;
    end
  end

  // read data; counters sampled live, no need to stop them
  always_comb begin
    next_rdata = '0;
    next_fault = (reg_req.rd || reg_req.wr) && !access_ok;
    if (reg_req.rd && access_ok) begin
      case (reg_req.sel)
        `SEL_CONTROL: next_rdata = {{(CW-`CTRL_WIDTH){1'b0}},
                                    counter_control_register};
        `SEL_COUNTER_ZERO: next_rdata = counter_value[0];
        `SEL_COUNTER_ONE: next_rdata = counter_value[1];
        default: next_fault = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= '0;
      reg_fault <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_fault <= next_fault;
    end
  end

  // pin pipeline: the pin register follows the last stage, LAG+1 clocks late
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_pipe[i] = {pin_pipe[i][LAG-2:0],
                      cfg[i].pin_mode ? ovf_flag[i] : inc_flag[i]};
      // debugger owns the pins; counter indication withheld
      next_pin[i] = breakpoint_mode ? breakpoint_match[i]
                                    : pin_pipe[i][LAG-1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_pipe <= '0;
      pin_out <= 2'h0;
    end else begin
      pin_pipe <= next_pipe;
      pin_out <= next_pin;
    end
  end

  assign indication_pin_zero = pin_out[0];
  assign indication_pin_one = pin_out[1];

  // assertions
  a_reset_clears_ctrl: assert property (@(posedge core_clk)
    $past(rst) |-> counter_control_register == `CONTROL_RESET)
    else $error("control register not cleared by reset");
  a_priv_write_block: assert property (@(posedge core_clk)
    disable iff (rst) (reg_req.wr && !access_ok && reg_req.sel == `SEL_CONTROL)
    |=> $stable(counter_control_register))
    else $error("control written outside level zero");
  a_disabled_stable: assert property (@(posedge core_clk)
    disable iff (rst) (cfg[0].count_control[1:0] == 2'h0 && !reg_req.wr)
    |=> $stable(counter_value[0]))
    else $error("disabled counter changed");
  a_dur_adds_one: assert property (@(posedge core_clk)
    disable iff (rst) (cfg[0].count_control == 3'h7 &&
      event_level[cfg[0].event_code] && !reg_req.wr)
    |=> counter_value[0] == $past(counter_value[0]) + 40'h1)
    else $error("duration counter did not add one");
  a_occ_adds_amount: assert property (@(posedge core_clk)
    disable iff (rst) (cfg[1].count_control == 3'h3 && !reg_req.wr)
    |=> counter_value[1] == $past(counter_value[1]) +
        $past(event_occur[cfg[1].event_code]))
    else $error("occurrence count wrong");
  a_pin_lag: assert property (@(posedge core_clk)
    disable iff (rst) ((!breakpoint_mode && !rst) [*7])
    |-> indication_pin_zero == $past(next_pipe[0][0], 6))
    else $error("pin lag mismatch");
  a_bp_hides_ctr: assert property (@(posedge core_clk)
    disable iff (rst) breakpoint_mode |=>
    indication_pin_one == $past(breakpoint_match[1]))
    else $error("counter shown in breakpoint mode");
  a_wrap_overflow: assert property (@(posedge core_clk)
    disable iff (rst) (ovf_flag[0] && !reg_req.wr)
    |=> counter_value[0] < 40'h2)
    else $error("counter did not wrap");

  // second counter: wrap, hold when disabled
  a_wrap_one: assert property (@(posedge core_clk)
    disable iff (rst) (ovf_flag[1] && !reg_req.wr)
    |=> counter_value[1] < 40'h2)
    else $error("counter one did not wrap");
  a_disabled_one: assert property (@(posedge core_clk)
    disable iff (rst) (cfg[1].count_control[1:0] == 2'h0 && !reg_req.wr)
    |=> $stable(counter_value[1]))
    else $error("disabled counter one changed");

  // privilege gating of the count codes
  a_priv_low_only: assert property (@(posedge core_clk)
    disable iff (rst) (cfg[0].count_control == 3'h1 &&
      current_privilege_level == 2'h3 && !reg_req.wr)
    |=> $stable(counter_value[0]))
    else $error("level three counted under low-level code");
  a_priv_high_only: assert property (@(posedge core_clk)
    disable iff (rst) (cfg[0].count_control == 3'h6 &&
      current_privilege_level != 2'h3 && !reg_req.wr)
    |=> $stable(counter_value[0]))
    else $error("low level counted under level-three code");
  a_occ_adds_zero: assert property (@(posedge core_clk)
    disable iff (rst) (cfg[0].count_control == 3'h3 && !reg_req.wr)
    |=> counter_value[0] == $past(counter_value[0]) +
        $past(event_occur[cfg[0].event_code]))
    else $error("occurrence count wrong on counter zero");

  // register access
  a_fault_refused: assert property (@(posedge core_clk)
    disable iff (rst) ((reg_req.rd || reg_req.wr) && !access_ok)
    |=> reg_fault)
    else $error("refused access gave no fault");
  a_ctrl_whole_word: assert property (@(posedge core_clk)
    disable iff (rst) (reg_req.wr && access_ok &&
      reg_req.sel == `SEL_CONTROL)
    |=> counter_control_register == $past(reg_req.wdata[`CTRL_WIDTH-1:0]))
    else $error("control word not taken whole");
  a_ctr_preset: assert property (@(posedge core_clk)
    disable iff (rst) (reg_req.wr && access_ok && sel_ctr[1])
    |=> counter_value[1] == $past(reg_req.wdata))
    else $error("counter one preset lost");
  a_live_read: assert property (@(posedge core_clk)
    disable iff (rst) (reg_req.rd && access_ok &&
      reg_req.sel == `SEL_COUNTER_ZERO)
    |=> reg_rdata == $past(counter_value[0]))
    else $error("running counter read wrong");

  // pins after reset and along the lag pipe
  a_reset_pins_low: assert property (@(posedge core_clk)
    rst |=> !indication_pin_zero && !indication_pin_one)
    else $error("indication pin high after reset");
  a_pin_lag_one: assert property (@(posedge core_clk)
    disable iff (rst) ((!breakpoint_mode && !rst) [*7])
    |-> indication_pin_one == $past(next_pipe[1][0], 6))
    else $error("pin one lag mismatch");
  a_pin_tracks_inc: assert property (@(posedge core_clk)
    disable iff (rst) ((!breakpoint_mode && !rst) [*7] ##0
      $past(!cfg[0].pin_mode && !reg_req.wr, 6))
    |-> indication_pin_zero == ($past(counter_value[0], 5) !=
        $past(counter_value[0], 6)))
    else $error("increment pin does not match counting");
  a_ovf_pin_quiet: assert property (@(posedge core_clk)
    disable iff (rst) ((!breakpoint_mode && !rst) [*7] ##0
      $past(cfg[1].pin_mode && !ovf_flag[1], 6))
    |-> !indication_pin_one)
    else $error("overflow pin raised without overflow");

  c_overflow_zero: cover property (@(posedge core_clk) ovf_flag[0]);
  c_double_inc: cover property (@(posedge core_clk)
    inc_flag[1] && event_occur[cfg[1].event_code] == 2'h2);
  c_pin_high: cover property (@(posedge core_clk) indication_pin_zero);
  c_bp_mode: cover property (@(posedge core_clk) breakpoint_mode);
  c_overflow_one: cover property (@(posedge core_clk) ovf_flag[1]);

endmodule

`default_nettype wire

// file: dual_event_counter_unit_test.sv
// self-checking bench for the dual event counter unit
// assumes header, package, design and pin model compiled before it
`timescale 1ns/100ps
`include "dual_event_counter_params.svh"
`default_nettype none
module dual_event_counter_unit_test
  import dual_event_counter_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  reg_req_s reg_req = '0;
  logic [1:0] current_privilege_level = 2'h0;
  logic [39:0] reg_rdata;
  logic reg_fault;
  logic [63:0][1:0] event_occur = '0;
  logic [63:0] event_level = '0;
  logic breakpoint_mode = 1'b0;
  logic [1:0] breakpoint_match = 2'h0;
  logic indication_pin_zero;
  logic indication_pin_one;
  logic [7:0] seen_zero;
  logic [7:0] seen_one;
  logic [7:0] p0;
  int failures = 0;
  int checked = 0;
  // expected count per row; row index is {count control, level 3}
  logic [1:0] exp_tab [16] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h0, 2'h2,
    2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1};

  dual_event_counter_unit dut (.core_clk(core_clk), .rst(rst),
    .reg_req(reg_req), .current_privilege_level(current_privilege_level),
    .reg_rdata(reg_rdata), .reg_fault(reg_fault),
    .event_occur(event_occur), .event_level(event_level),
    .breakpoint_mode(breakpoint_mode),
    .breakpoint_match(breakpoint_match),
    .indication_pin_zero(indication_pin_zero),
    .indication_pin_one(indication_pin_one));
  pin_watch_model watch (.core_clk(core_clk), .rst(rst),
    .pin_zero(indication_pin_zero), .pin_one(indication_pin_one),
    .seen_zero(seen_zero), .seen_one(seen_one));

  // 50 MHz core clock
  initial forever #10 core_clk = ~core_clk;

  task automatic chk_val(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask
  // one access; returns in the cycle where read data and fault stand
  task automatic acc(input logic r, input logic w, input logic [1:0] s,
    input logic [39:0] d);
    @(negedge core_clk);
    reg_req <= {r, w, s, d};
    @(negedge core_clk);
    reg_req <= '0;
  endtask
  task automatic end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_sim;
  end

  // main sequence
  initial begin
    repeat (12) @(negedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      acc(1'b0, 1'b1, `SEL_CONTROL, 40'h0);
      acc(1'b0, 1'b1, `SEL_COUNTER_ZERO, 40'h0);
      acc(1'b0, 1'b1, `SEL_CONTROL, {31'h0, i[3:1], 6'h05});
      p0 = seen_zero;
      @(negedge core_clk);
      current_privilege_level <= i[0] ? 2'h3 : 2'h0;
      event_occur[5] <= 2'h2;
      event_level[5] <= 1'b1;
      @(negedge core_clk);
      current_privilege_level <= 2'h0;
      event_occur[5] <= 2'h0;
      event_level[5] <= 1'b0;
      repeat (8) @(negedge core_clk);
      acc(1'b1, 1'b0, `SEL_COUNTER_ZERO, 40'h0);
      chk_val(reg_rdata, {38'h0, exp_tab[i]});
      chk_val({32'h0, seen_zero - p0}, {39'h0, exp_tab[i] != 2'h0});
    end
    // second reset in mid-run clears everything
    rst <= 1'b1;
    repeat (2) @(negedge core_clk);
    rst <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      acc(1'b1, 1'b0, s[1:0], 40'h0);
      chk_val(reg_rdata, 40'h0);
    end
    chk_bit(indication_pin_zero | indication_pin_one, 1'b0);
    // refused access above level zero, and an unmapped read
    current_privilege_level <= 2'h1;
    acc(1'b0, 1'b1, `SEL_CONTROL, 40'h3FF);
    chk_bit(reg_fault, 1'b1);
    current_privilege_level <= 2'h0;
    acc(1'b1, 1'b0, `SEL_CONTROL, 40'h0);
    chk_val(reg_rdata, 40'h0);
    chk_bit(reg_fault, 1'b0);
    acc(1'b1, 1'b0, 2'h3, 40'h0);
    chk_bit(reg_fault, 1'b1);
    // preset near the top, then step across bit 39 with a double event
    acc(1'b0, 1'b1, `SEL_COUNTER_ONE, 40'hFFFFFFFFFE);
    acc(1'b0, 1'b1, `SEL_CONTROL, 40'h0002C10000);
    p0 = seen_one;
    @(negedge core_clk);
    event_occur[1] <= 2'h1;
    @(negedge core_clk);
    event_occur[1] <= 2'h2;
    @(negedge core_clk);
    event_occur[1] <= 2'h0;
    repeat (8) @(negedge core_clk);
    acc(1'b1, 1'b0, `SEL_COUNTER_ONE, 40'h0);
    chk_val(reg_rdata, 40'h1);
    chk_val({32'h0, seen_one - p0}, 40'h1);
    // breakpoint sharing hides a duration count running across bit 39
    acc(1'b0, 1'b1, `SEL_COUNTER_ZERO, 40'hFFFFFFFFFE);
    acc(1'b0, 1'b1, `SEL_CONTROL, 40'h1C5);
    acc(1'b1, 1'b0, `SEL_CONTROL, 40'h0);
    chk_val(reg_rdata, 40'h1C5);
    breakpoint_mode <= 1'b1;
    breakpoint_match <= 2'h2;
    event_level[5] <= 1'b1;
    repeat (8) @(negedge core_clk);
    chk_bit(indication_pin_zero, 1'b0);
    chk_bit(indication_pin_one, 1'b1);
    // nine true clocks before the read edge: wraps to seven
    acc(1'b1, 1'b0, `SEL_COUNTER_ZERO, 40'h0);
    chk_val(reg_rdata, 40'h7);
    end_sim;
  end
endmodule
`default_nettype wire

// file: pin_watch_model.sv
// model of the outside hardware that watches both indication pins
// assumes the pins change only after a rising core_clk edge
`timescale 1ns/100ps
`default_nettype none
module pin_watch_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pins under watch
  input wire logic pin_zero,
  input wire logic pin_one,
  // high cycles seen on each pin
  output logic [7:0] seen_zero,
  output logic [7:0] seen_one
);
  // counts high cycles, not edges, so a held pin shows its length
  always_ff @(posedge core_clk) begin
    if (rst) begin
      seen_zero <= 8'h00;
      seen_one <= 8'h00;
    end else begin
      seen_zero <= seen_zero + {7'h00, pin_zero};
      seen_one <= seen_one + {7'h00, pin_one};
    end
  end
endmodule
`default_nettype wire
